//--- rtl/aobsc_defs.svh
// Register indices, field positions and reset values of the angle output slave
`ifndef AOBSC_DEFS_SVH
`define AOBSC_DEFS_SVH

// Register indices inside the window; byte address is four times the index
`define AOBSC_IDX_ANGLE0      2'h0
`define AOBSC_IDX_ANGLE1      2'h1
`define AOBSC_IDX_CSR         2'h2
`define AOBSC_IDX_RELAY_STAT  2'h3
`define AOBSC_ADDR_ANGLE0     12'h000
`define AOBSC_ADDR_ANGLE1     12'h004
`define AOBSC_ADDR_CSR        12'h008
`define AOBSC_ADDR_RELAY_STAT 12'h00C
// Number of register indices in the window
`define AOBSC_WINDOW_REGS     4

// Control/status bit positions within the 16-bit register word
`define AOBSC_CSR_FAIL_OFF_BIT 15
`define AOBSC_CSR_FIELD0_BIT   14
`define AOBSC_CSR_LOOP0_BIT    13
`define AOBSC_CSR_FIELD1_BIT   12
`define AOBSC_CSR_LOOP1_BIT    11
`define AOBSC_CSR_LSB          11
`define AOBSC_CSR_WIDTH        5

// Reset values
`define AOBSC_BYTE_RST     8'h00
`define AOBSC_CSR_RST      5'h00
`define AOBSC_PRDATA_RST   32'h0000_0000
`define AOBSC_FAIL_LIT_RST 1'h1

`endif

//--- rtl/aobsc_pkg.sv
// Types shared by the angle output slave modules
package aobsc_pkg;

  // Register selected by the current bus address
  typedef enum logic [4:0] {
    AOBSC_SEL_ANGLE0 = 5'b00001,
    AOBSC_SEL_ANGLE1 = 5'b00010,
    AOBSC_SEL_CSR    = 5'b00100,
    AOBSC_SEL_STAT   = 5'b01000,
    AOBSC_SEL_NONE   = 5'b10000
  } aobsc_sel_type;

  // Control/status register contents, msb first as laid out in the word
  typedef struct packed {
    logic fail_off;
    logic field_connect_chan0;
    logic loopback_connect_chan0;
    logic field_connect_chan1;
    logic loopback_connect_chan1;
  } aobsc_csr_type;

  // Whole state of the top module
  typedef struct packed {
    logic [3:0][7:0] angle_bytes;
    aobsc_csr_type   control_status_reg;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            fail_led_lit;
    logic            chan0_field_relay;
    logic            chan1_field_relay;
    logic [1:0]      angle_load;
  } aobsc_top_state_type;

  // Whole state of the loopback interlock
  typedef struct packed {
    logic chan0_loopback_relay;
    logic chan1_loopback_relay;
  } aobsc_lock_state_type;

endpackage

//--- rtl/aobsc_interlock.sv
// Loopback relay interlock: at most one channel on the test backplane
`timescale 1ns/10ps
`default_nettype none

module aobsc_interlock (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic loop_req_chan0,
  input  wire logic loop_req_chan1,
  output logic      chan0_loopback_relay,
  output logic      chan1_loopback_relay
);
  import aobsc_pkg::*;

  aobsc_lock_state_type state_reg;
  aobsc_lock_state_type state_next;

  logic grant0;
  logic grant1;

  always_comb begin
    // A relay may only close while the other is open; the holder keeps it
    grant0 = loop_req_chan0 & ~state_reg.chan1_loopback_relay;          // [RULE10] [RULE14]
    // Same-cycle request from idle goes to channel 0
    grant1 = loop_req_chan1 & ~state_reg.chan0_loopback_relay & ~grant0; // [RULE10] [RULE14]
    state_next                      = state_reg;
    state_next.chan0_loopback_relay = grant0;
    state_next.chan1_loopback_relay = grant1;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg.chan0_loopback_relay <= 1'b0; // [RULE6]
      state_reg.chan1_loopback_relay <= 1'b0; // [RULE6]
    end else begin
      state_reg <= state_next;
    end
  end

  assign chan0_loopback_relay = state_reg.chan0_loopback_relay;
  assign chan1_loopback_relay = state_reg.chan1_loopback_relay;

endmodule // aobsc_interlock

`default_nettype wire

//--- rtl/aobsc_top.sv
// APB register slave for the dual-channel angle output board
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "aobsc_defs.svh"

// Contract
// RULE1: Accept byte and word writes via strobes
// RULE2: Decode word address to pick the register
// RULE3: Acknowledge every addressed transfer
// RULE4: Four byte-wide angle data registers
// RULE5: Five-bit control register drives LED, relays
// RULE6: Reset clears all registers, relays open
// RULE7: Fail indicator lit while its bit clear
// RULE8: Angle registers hold value until rewritten
// RULE9: Two field relays, two loopback relays
// RULE10: Interlock keeps loopback relays mutually exclusive
// RULE11: Software can open field relays
// RULE12: Master drives isolation via loopback bits
// RULE13: Bits 14..11 map to the four relays
// RULE14: First loopback relay set keeps priority
// RULE15: Device window spans four register words
// RULE16: Byte pairs form each channel angle word
module aobsc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [15:0]            angle_chan0,
  output logic [15:0]            angle_chan1,
  output logic                   angle_load_chan0,
  output logic                   angle_load_chan1,
  output logic                   fail_led_lit,
  output logic                   chan0_field_relay,
  output logic                   chan1_field_relay,
  output logic                   chan0_loopback_relay,
  output logic                   chan1_loopback_relay
);
  import aobsc_pkg::*;

  // The decode needs the two index bits plus the byte bits
  generate
    if (ADDR_W < 4) begin : g_bad_addr_w
      $error("aobsc_top: ADDR_W must be at least 4");
    end
  endgenerate

  aobsc_top_state_type state_reg;
  aobsc_top_state_type state_next;

  aobsc_sel_type sel;
  logic          in_window;
  logic [1:0]    reg_index;
  logic          setup_phase;
  logic          access_done;
  logic          wr_done;
  logic [15:0]   rd_word;
  logic [15:0]   wdata16;
  logic [4:0]    csr_bits;
  logic [4:0]    relay_bits;
  logic          lock_loop0;
  logic          lock_loop1;

  // Address decode: window check, then the word index
  always_comb begin
    in_window = (paddr >> 4) == '0;             // [RULE15]
    reg_index = paddr[3:2];                     // [RULE2]
    if (!in_window) begin
      sel = AOBSC_SEL_NONE;
    end else if (reg_index == `AOBSC_IDX_ANGLE0) begin
      sel = AOBSC_SEL_ANGLE0;                   // [RULE2]
    end else if (reg_index == `AOBSC_IDX_ANGLE1) begin
      sel = AOBSC_SEL_ANGLE1;                   // [RULE2]
    end else if (reg_index == `AOBSC_IDX_CSR) begin
      sel = AOBSC_SEL_CSR;                      // [RULE2]
    end else begin
      sel = AOBSC_SEL_STAT;
    end
  end

  // Bus phases: answer is prepared in setup, taken in the access phase
  always_comb begin
    setup_phase = psel & ~penable;
    access_done = psel & penable & state_reg.pready;   // [RULE3]
    wr_done     = access_done & pwrite & ~state_reg.pslverr;
    wdata16     = pwdata[15:0];
    csr_bits    = state_reg.control_status_reg;
    relay_bits  = {state_reg.fail_led_lit,
                   state_reg.chan0_field_relay,
                   lock_loop0,
                   state_reg.chan1_field_relay,
                   lock_loop1};
  end

  // Read value of the selected register, narrow data in the low half
  always_comb begin
    rd_word = 16'h0000;
    case (sel)
      AOBSC_SEL_ANGLE0: begin
        rd_word = {state_reg.angle_bytes[1], state_reg.angle_bytes[0]}; // [RULE16]
      end
      AOBSC_SEL_ANGLE1: begin
        rd_word = {state_reg.angle_bytes[3], state_reg.angle_bytes[2]}; // [RULE16]
      end
      AOBSC_SEL_CSR: begin
        rd_word = {csr_bits, 11'h000};
      end
      AOBSC_SEL_STAT: begin
        rd_word = {relay_bits, 11'h000};
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Next state
  always_comb begin
    state_next            = state_reg;
    state_next.angle_load = 2'b00;

    // Ready rises in the first access cycle and falls after it
    state_next.pready = setup_phase;                                   // [RULE3]
    if (setup_phase) begin
      state_next.pslverr = (sel == AOBSC_SEL_NONE) ||
                           ((sel == AOBSC_SEL_STAT) && pwrite);
      if (pwrite || (sel == AOBSC_SEL_NONE)) begin
        state_next.prdata = `AOBSC_PRDATA_RST;
      end else begin
        state_next.prdata = {16'h0000, rd_word};
      end
    end else if (!psel) begin
      state_next.pslverr = 1'b0;
      state_next.prdata  = `AOBSC_PRDATA_RST;
    end

    // Angle byte registers keep their value unless their lane is written
    if (wr_done && (sel == AOBSC_SEL_ANGLE0)) begin
      if (pstrb[0]) begin
        state_next.angle_bytes[0] = wdata16[7:0];                      // [RULE1] [RULE4]
      end
      if (pstrb[1]) begin
        state_next.angle_bytes[1] = wdata16[15:8];                     // [RULE1] [RULE4]
      end
      state_next.angle_load[0] = pstrb[0] | pstrb[1];                   // [RULE8]
    end else if (wr_done && (sel == AOBSC_SEL_ANGLE1)) begin
      if (pstrb[0]) begin
        state_next.angle_bytes[2] = wdata16[7:0];                      // [RULE1] [RULE4]
      end
      if (pstrb[1]) begin
        state_next.angle_bytes[3] = wdata16[15:8];                     // [RULE1] [RULE4]
      end
      state_next.angle_load[1] = pstrb[0] | pstrb[1];                   // [RULE8]
    end else if (wr_done && (sel == AOBSC_SEL_CSR) && pstrb[1]) begin
      // All five control bits sit in the upper byte lane
      state_next.control_status_reg = aobsc_csr_type'(
        wdata16[`AOBSC_CSR_FAIL_OFF_BIT:`AOBSC_CSR_LSB]);              // [RULE5] [RULE12]
    end

    // Indicator and field relays follow the control bits one edge later
    state_next.fail_led_lit      = ~state_reg.control_status_reg.fail_off;             // [RULE7]
    state_next.chan0_field_relay = state_reg.control_status_reg.field_connect_chan0;   // [RULE9] [RULE11] [RULE13]
    state_next.chan1_field_relay = state_reg.control_status_reg.field_connect_chan1;   // [RULE9] [RULE11] [RULE13]
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg.angle_bytes[0]    <= `AOBSC_BYTE_RST;                  // [RULE6]
      state_reg.angle_bytes[1]    <= `AOBSC_BYTE_RST;                  // [RULE6]
      state_reg.angle_bytes[2]    <= `AOBSC_BYTE_RST;                  // [RULE6]
      state_reg.angle_bytes[3]    <= `AOBSC_BYTE_RST;                  // [RULE6]
      state_reg.control_status_reg               <= aobsc_csr_type'(`AOBSC_CSR_RST);  // [RULE6]
      state_reg.pready            <= 1'b0;
      state_reg.pslverr           <= 1'b0;
      state_reg.prdata            <= `AOBSC_PRDATA_RST;
      state_reg.fail_led_lit      <= `AOBSC_FAIL_LIT_RST;              // [RULE7]
      state_reg.chan0_field_relay <= 1'b0;                             // [RULE6]
      state_reg.chan1_field_relay <= 1'b0;                             // [RULE6]
      state_reg.angle_load        <= 2'b00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Loopback relays pass through the interlock
  aobsc_interlock u_interlock (
    .sys_clk              (sys_clk),
    .nrst                 (nrst),
    .loop_req_chan0       (state_reg.control_status_reg.loopback_connect_chan0),       // [RULE13]
    .loop_req_chan1       (state_reg.control_status_reg.loopback_connect_chan1),       // [RULE13]
    .chan0_loopback_relay (lock_loop0),
    .chan1_loopback_relay (lock_loop1)
  );

  assign prdata               = state_reg.prdata;
  assign pready               = state_reg.pready;
  assign pslverr              = state_reg.pslverr;
  assign angle_chan0          = {state_reg.angle_bytes[1], state_reg.angle_bytes[0]}; // [RULE16]
  assign angle_chan1          = {state_reg.angle_bytes[3], state_reg.angle_bytes[2]}; // [RULE16]
  assign angle_load_chan0     = state_reg.angle_load[0];
  assign angle_load_chan1     = state_reg.angle_load[1];
  assign fail_led_lit         = state_reg.fail_led_lit;
  assign chan0_field_relay    = state_reg.chan0_field_relay;
  assign chan1_field_relay    = state_reg.chan1_field_relay;
  assign chan0_loopback_relay = lock_loop0;                             // [RULE9]
  assign chan1_loopback_relay = lock_loop1;                             // [RULE9]

endmodule // aobsc_top

`default_nettype wire

//--- dv/aobsc_sva.sv
// Port checker for the angle output slave
`timescale 1ns/10ps
`default_nettype none
module aobsc_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [15:0]       angle_chan0,
  input wire logic              fail_led_lit,
  input wire logic              chan0_field_relay,
  input wire logic              chan0_loopback_relay,
  input wire logic              chan1_loopback_relay
);
  logic csr_wr;
  assign csr_wr = psel && penable && pready && pwrite && paddr == ADDR_W'(8) && pstrb[1];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready held");
  property p_zws; psel && !penable |=> pready; endproperty
  a_zws: assert property (p_zws) else $error("no acknowledge");
  property p_led; csr_wr |=> ##1 fail_led_lit == !$past(pwdata[15], 2); endproperty
  a_led: assert property (p_led) else $error("fail indicator wrong");
  property p_fld; csr_wr |=> ##1 chan0_field_relay == $past(pwdata[14], 2); endproperty
  a_fld: assert property (p_fld) else $error("field relay wrong");
  property p_excl; !(chan0_loopback_relay && chan1_loopback_relay); endproperty
  a_excl: assert property (p_excl) else $error("both loopbacks on");
  property p_prio; $rose(chan1_loopback_relay) |-> !$past(chan0_loopback_relay); endproperty
  a_prio: assert property (p_prio) else $error("loopback taken over");
  property p_hold;
    !$stable(angle_chan0) |-> $past(psel && penable && pwrite && paddr == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("angle changed unwritten");
  property p_range;
    psel && !penable && paddr[ADDR_W-1:4] != '0 |=> pslverr && prdata == '0;
  endproperty
  a_range: assert property (p_range) else $error("outside window accepted");
endmodule // aobsc_sva
bind aobsc_top aobsc_sva #(.ADDR_W(ADDR_W)) aobsc_sva_inst (
  .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .angle_chan0, .fail_led_lit, .chan0_field_relay, .chan0_loopback_relay,
  .chan1_loopback_relay
);
`default_nettype wire

//--- dv/aobsc_apb_master.sv
// Behavioural bus master that drives the slave
`timescale 1ns/10ps
`default_nettype none
module aobsc_apb_master #(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [ADDR_W-1:0]      paddr,
  output logic [31:0]            pwdata,
  output logic [3:0]             pstrb,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  initial begin
    {psel, penable, pwrite} = 3'b000;
    {paddr, pwdata, pstrb} = '0;
  end
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err,
                      output bit ok);
    @(posedge sys_clk);
    {psel, penable, pwrite} <= {2'b10, w};
    {paddr, pwdata, pstrb} <= {a, d, s};
    @(posedge sys_clk);
    penable <= 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge sys_clk);
      ok = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    // Released lines show the inverse so stale values cannot pass
    {paddr, pwdata, pstrb} <= ~{a, d, s};
  endtask
endmodule // aobsc_apb_master
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the angle output slave
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk;
  logic        nrst;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, outs;
  logic [3:0]  pstrb;
  logic [15:0] angle_chan0, angle_chan1;
  logic        fail_led_lit, chan0_field_relay, chan1_field_relay;
  logic        chan0_loopback_relay, chan1_loopback_relay;
  int          n_fail, n_checks;
  assign outs = {27'h0, fail_led_lit, chan0_field_relay, chan0_loopback_relay,
                 chan1_field_relay, chan1_loopback_relay};
  aobsc_top aobsc_top_inst (
    .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .angle_chan0, .angle_chan1, .angle_load_chan0(), .angle_load_chan1(),
    .fail_led_lit, .chan0_field_relay, .chan1_field_relay, .chan0_loopback_relay,
    .chan1_loopback_relay
  );
  aobsc_apb_master aobsc_apb_master_inst (
    .sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr
  );
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Settles past the relay pipeline before anything is sampled
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    bit ok;
    aobsc_apb_master_inst.xfer(w, a, d, s, rd, err, ok);
    if (!ok) begin
      n_fail++;
      results();
    end
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  initial begin
    n_fail = 0;
    n_checks = 0;
    nrst = 1'b0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("outputs", 32'h10, outs);
    acc(1'b0, 12'h00C, 32'h0, 4'h0);
    chk("status", 32'h8000, rd);
    $display("Reset test done");
    acc(1'b1, 12'h000, 32'h1234, 4'h3);
    acc(1'b1, 12'h004, 32'h5600, 4'h2);
    acc(1'b1, 12'h000, 32'hFFAB, 4'h1);
    chk("angles", 32'h12AB_5600, {angle_chan0, angle_chan1});
    acc(1'b0, 12'h000, 32'h0, 4'h0);
    chk("angle read", 32'h12AB, rd);
    $display("Angle test done");
    for (int b = 11; b < 15; b++) begin
      acc(1'b1, 12'h008, 32'h8000 | (32'h1 << b), 4'h3);
      chk("relays", 32'h1 << (b - 11), outs);
      acc(1'b0, 12'h00C, 32'h0, 4'h0);
      chk("status", 32'h1 << b, rd);
    end
    acc(1'b1, 12'h008, 32'h0, 4'h1);
    chk("lane0 only", 32'h08, outs);
    acc(1'b1, 12'h008, 32'h2000, 4'h3);
    acc(1'b1, 12'h008, 32'h2800, 4'h3);
    chk("first keeps", 32'h14, outs);
    acc(1'b1, 12'h008, 32'h0800, 4'h3);
    chk("handover", 32'h11, outs);
    acc(1'b1, 12'h008, 32'h2800, 4'h3);
    chk("holder keeps", 32'h11, outs);
    $display("Relay test done");
    acc(1'b1, 12'h00C, 32'hFFFF, 4'h3);
    chk("status write", 32'h1, {31'h0, err});
    acc(1'b1, 12'h014, 32'h0, 4'h3);
    chk("outside write", 32'h1_5600, {15'h0, err, angle_chan1});
    acc(1'b0, 12'h010, 32'h0, 4'h0);
    chk("outside read", 32'h0, rd);
    $display("Refusal test done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("outputs", 32'h10, outs);
    chk("angles", 32'h0, {angle_chan0, angle_chan1});
    $display("Second reset test done");
    results();
  end
endmodule // testbench
`default_nettype wire
